// ### logic/pss_frontend.sv
// Sensing front end of a PM synchronous motor drive: encoder speed and position,
// rotor alignment, ADC trigger delay, third phase current, DC bus filter, temperature.
// Assumes encoder, run switch and PWM sync arrive asynchronously; ADC results are clk-synchronous.
// Summary of operation
// - Speed evaluated once per period, four edges/line
// - Interval timer runs at half system clock, prescaled by 3
// - Speed scaled so full scale is maximum speed
// - Calculation period stays below 0x7FFF timer counts
// - Alignment forces position zero, applies alignment current
// - After settling clear encoder, then zero current
// - Alignment runs once, first stop-to-run only
// - Current sampled mid PWM period, low sides on
// - Delay timer turns sync into ADC start
// - Third current makes the three sum zero
// - Sector picks which phase is computed
// - DC bus smoothed by first-order recursive filter
// - Filter starts from average of N samples
// - Temperature is (voltage minus offset) over slope
// - Phase A edge captures both counters together
// - Capture re-armed each period, first edge disarms
`timescale 1ns/100ps
`default_nettype none
module pss_frontend #(
  parameter int CALC_PERIOD_CYCLES = int'(pss_pkg::CALC_CYCLES),
  parameter int ALIGN_HOLD_CYCLES = int'(pss_pkg::ALIGN_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic enc_a, // Encoder phase A pin
  input wire logic enc_b, // Encoder phase B pin
  input wire logic run_switch, // Run (1) / stop (0) switch pin
  input wire logic pwm_sync, // Reload pulse from PWM generator
  input wire logic [15:0] sample_delay, // Cycles from sync to ADC start
  input wire logic adc_done, // Current conversions ready
  input wire logic [2:0] sector, // Voltage sector 1..6
  input wire logic [15:0] adc_ia, // Phase currents, Q15 signed
  input wire logic [15:0] adc_ib,
  input wire logic [15:0] adc_ic,
  input wire logic bus_sample_valid, // New DC bus sample
  input wire logic [15:0] bus_sample, // DC bus voltage, unsigned
  input wire logic [15:0] filter_coef, // Filter coefficient C, unsigned, scaled by 2^16
  input wire logic temp_sample_valid, // New temperature sample
  input wire logic [15:0] temp_sense_mv10, // Diode voltage in 0.1 mV
  output logic [15:0] speed, // Q15 signed, full scale = max speed
  output logic speed_valid,
  output logic [11:0] electrical_position, // Encoder position, zero while forced
  output logic [15:0] flux_current_ref, // Q15
  output logic align_done,
  output logic adc_start,
  output logic [15:0] phase_a_current,
  output logic [15:0] phase_b_current,
  output logic [15:0] phase_c_current,
  output logic current_valid,
  output logic [15:0] bus_voltage_filtered,
  output logic bus_voltage_valid,
  output logic [15:0] temperature_c, // Signed whole degrees
  output logic temperature_valid
);
  import pss_pkg::*;

  // Clip an 18-bit signed value into Q15
  function automatic logic [15:0] sat16(input logic [17:0] v);
    if (!v[17] && v[16:15] != 2'b00) begin
      sat16 = 16'h7fff;
    end else if (v[17] && v[16:15] != 2'b11) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  typedef struct packed {
    logic [2:0] a_sy, b_sy, run_sy, pwm_sy; // Two sync stages plus edge history
    logic [15:0] pulse_count_timer; // Signed edge counter
    logic [11:0] pos; // Position inside one turn
    logic [3:0] pre; // Interval tick prescaler
    logic [15:0] itv; // Interval timer
    logic [31:0] per; // Calculation period counter
    logic armed; // Capture enabled
    logic [15:0] cap_n, cap_t, prev_n, prev_t;
    logic neg; // Sign of the pending speed
    logic div_go;
    logic [15:0] div_n, div_t; // Held divider operands
    logic [15:0] speed;
    logic speed_valid;
    pss_align_t al;
    logic aligned; // Alignment already done once
    logic [31:0] al_cnt;
    logic [15:0] id_ref;
    logic [11:0] el_pos;
    logic dly_busy;
    logic [15:0] dly_cnt, sample_delay_timer;
    logic adc_start;
    logic [15:0] ia, ib, ic;
    logic cur_valid;
    logic bus_init; // Still averaging start-up samples
    logic [4:0] bus_n;
    logic [20:0] bus_sum;
    logic [15:0] bus_filt;
    logic bus_valid;
    logic [15:0] temp;
    logic temp_valid;
  } pss_state_t;

  pss_state_t st_ff, nxt_st;
  logic div_done;
  logic [39:0] div_quo;
  logic a_edge, quad_step, quad_up, period_end;
  logic [15:0] dn, dn_abs, dt;
  logic [17:0] third;
  logic [16:0] bus_diff;
  logic [32:0] bus_prod;
  logic [17:0] bus_next;
  logic [16:0] temp_diff;
  logic [32:0] temp_prod;

  pss_divider u_div (
    .clk(clk),
    .rst(rst),
    .start(st_ff.div_go),
    .dividend({16'h0000, SPEED_K_W} * {24'h000000, st_ff.div_n}),
    .divisor(st_ff.div_t),
    .done(div_done),
    .quotient(div_quo)
  );

  // All next-state logic of the block
  always_comb begin
    nxt_st = st_ff;
    // Sync chains: stage 1 feeds stage 2 only, logic reads stages 2 and 3
    nxt_st.a_sy = {st_ff.a_sy[1:0], enc_a};
    nxt_st.b_sy = {st_ff.b_sy[1:0], enc_b};
    nxt_st.run_sy = {st_ff.run_sy[1:0], run_switch};
    nxt_st.pwm_sy = {st_ff.pwm_sy[1:0], pwm_sync};
    a_edge = st_ff.a_sy[2] ^ st_ff.a_sy[1];
    quad_step = a_edge | (st_ff.b_sy[2] ^ st_ff.b_sy[1]);
    // Forward when new A differs from old B
    quad_up = st_ff.a_sy[1] ^ st_ff.b_sy[2];
    dn = st_ff.cap_n - st_ff.prev_n;
    dn_abs = dn[15] ? 16'h0000 - dn : dn;
    dt = st_ff.cap_t - st_ff.prev_t;
    third = 18'h00000;
    bus_diff = 17'h00000;
    bus_prod = 33'h000000000;
    bus_next = 18'h00000;
    temp_diff = 17'h00000;
    temp_prod = 33'h000000000;

    // Every quadrature edge counts once, so one line gives four counts
    if (quad_step) begin
      nxt_st.pulse_count_timer = quad_up ? st_ff.pulse_count_timer + 16'h0001
                                         : st_ff.pulse_count_timer - 16'h0001;
      if (quad_up) begin
        nxt_st.pos = (st_ff.pos == POS_WRAP) ? 12'h000 : st_ff.pos + 12'h001;
      end else begin
        nxt_st.pos = (st_ff.pos == 12'h000) ? POS_WRAP : st_ff.pos - 12'h001;
      end
    end

    // Interval tick every ITV_DIV cycles: half clock, prescaled to keep the period under 0x7fff
    if (st_ff.pre == ITV_DIV - 4'h1) begin
      nxt_st.pre = 4'h0;
      nxt_st.itv = st_ff.itv + 16'h0001;
    end else begin
      nxt_st.pre = st_ff.pre + 4'h1;
    end

    period_end = (st_ff.per == 32'(CALC_PERIOD_CYCLES - 1));
    // First phase A edge after arming captures both counters in the same cycle
    if (st_ff.armed && a_edge && !period_end) begin
      nxt_st.cap_n = st_ff.pulse_count_timer;
      nxt_st.cap_t = st_ff.itv;
      nxt_st.armed = 1'b0;
    end

    // Calculation period: evaluate the last capture, then re-arm
    nxt_st.per = period_end ? 32'h00000000 : st_ff.per + 32'h00000001;
    nxt_st.div_go = 1'b0;
    nxt_st.speed_valid = 1'b0;
    if (period_end) begin
      nxt_st.armed = 1'b1;
      if (!st_ff.armed) begin
        // A capture arrived; nonzero differences go to the divider
        nxt_st.prev_n = st_ff.cap_n;
        nxt_st.prev_t = st_ff.cap_t;
        nxt_st.neg = dn[15];
        if (dn == 16'h0000 || dt == 16'h0000) begin
          nxt_st.speed = 16'h0000;
          nxt_st.speed_valid = 1'b1;
        end else begin
          nxt_st.div_go = 1'b1;
          nxt_st.div_n = dn_abs;
          nxt_st.div_t = dt;
        end
      end else begin
        // No edge in a whole period: below the lowest measurable speed
        nxt_st.speed = 16'h0000;
        nxt_st.speed_valid = 1'b1;
      end
    end
    // Quotient is k*N/T in Q15, clipped at the maximum speed
    if (div_done) begin
      nxt_st.speed = (div_quo > {24'h000000, SPEED_FULL}) ? SPEED_FULL : div_quo[15:0];
      if (st_ff.neg) begin
        nxt_st.speed = 16'h0000 - nxt_st.speed;
      end
      nxt_st.speed_valid = 1'b1;
    end

    // Alignment sequence
    unique case (st_ff.al)
      PSS_AL_IDLE: begin
        // Only the first stop-to-run change starts it
        if (st_ff.run_sy[1] && !st_ff.run_sy[2] && !st_ff.aligned) begin
          nxt_st.al = PSS_AL_HOLD;
          nxt_st.al_cnt = 32'h00000000;
          nxt_st.id_ref = ALIGN_CURRENT;
        end
      end
      PSS_AL_HOLD: begin
        // Rotor settles under the alignment current
        nxt_st.al_cnt = st_ff.al_cnt + 32'h00000001;
        if (st_ff.al_cnt == 32'(ALIGN_HOLD_CYCLES - 1)) begin
          nxt_st.al = PSS_AL_CLEAR;
          nxt_st.pos = 12'h000;
        end
      end
      PSS_AL_CLEAR: begin
        // Encoder already cleared; only now drop the current
        nxt_st.id_ref = 16'h0000;
        nxt_st.al = PSS_AL_DONE;
        nxt_st.aligned = 1'b1;
      end
      PSS_AL_DONE: begin
        nxt_st.al = PSS_AL_DONE;
      end
    endcase
    // Position reads zero from alignment start until the encoder is cleared
    nxt_st.el_pos = (nxt_st.al == PSS_AL_HOLD) ? 12'h000 : nxt_st.pos;

    // Sync rising edge loads the delay; expiry starts the ADC near mid period
    nxt_st.adc_start = 1'b0;
    if (st_ff.pwm_sy[1] && !st_ff.pwm_sy[2]) begin
      nxt_st.sample_delay_timer = sample_delay;
      nxt_st.dly_cnt = sample_delay;
      nxt_st.dly_busy = 1'b1;
    end else if (st_ff.dly_busy) begin
      if (st_ff.dly_cnt == 16'h0000) begin
        nxt_st.adc_start = 1'b1;
        nxt_st.dly_busy = 1'b0;
      end else begin
        nxt_st.dly_cnt = st_ff.dly_cnt - 16'h0001;
      end
    end

    // Third phase from the other two, chosen by sector, clipped to Q15
    nxt_st.cur_valid = 1'b0;
    if (adc_done) begin
      nxt_st.ia = adc_ia;
      nxt_st.ib = adc_ib;
      nxt_st.ic = adc_ic;
      nxt_st.cur_valid = 1'b1;
      unique case (sector)
        3'h1, 3'h6: begin
          third = 18'h00000 - {{2{adc_ib[15]}}, adc_ib} - {{2{adc_ic[15]}}, adc_ic};
          nxt_st.ia = sat16(third);
        end
        3'h2, 3'h3: begin
          third = 18'h00000 - {{2{adc_ia[15]}}, adc_ia} - {{2{adc_ic[15]}}, adc_ic};
          nxt_st.ib = sat16(third);
        end
        default: begin
          // Sectors 4 and 5; an illegal sector also rebuilds phase C
          third = 18'h00000 - {{2{adc_ib[15]}}, adc_ib} - {{2{adc_ia[15]}}, adc_ia};
          nxt_st.ic = sat16(third);
        end
      endcase
    end

    // DC bus: block average first, then y += C*(x - y)
    nxt_st.bus_valid = 1'b0;
    if (bus_sample_valid) begin
      if (st_ff.bus_init) begin
        nxt_st.bus_sum = st_ff.bus_sum + {5'h00, bus_sample};
        nxt_st.bus_n = st_ff.bus_n + 5'h01;
        if (st_ff.bus_n == BUS_INIT_N - 5'h01) begin
          nxt_st.bus_filt = 16'(nxt_st.bus_sum >> BUS_INIT_LOG2);
          nxt_st.bus_init = 1'b0;
          nxt_st.bus_valid = 1'b1;
        end
      end else begin
        bus_diff = {1'b0, bus_sample} - {1'b0, st_ff.bus_filt};
        bus_prod = $signed(bus_diff) * $signed({1'b0, filter_coef});
        bus_next = {2'b00, st_ff.bus_filt} + {bus_prod[32], bus_prod[32:16]};
        nxt_st.bus_filt = bus_next[17] ? 16'h0000 : (bus_next[16] ? 16'hffff : bus_next[15:0]);
        nxt_st.bus_valid = 1'b1;
      end
    end

    // Temperature: (b - v) * (2^16 / -a), upper 16 bits kept, so a positive slope result
    nxt_st.temp_valid = 1'b0;
    if (temp_sample_valid) begin
      temp_diff = {1'b0, TEMP_B_W} - {1'b0, temp_sense_mv10};
      temp_prod = $signed(temp_diff) * $signed({1'b0, TEMP_MUL});
      nxt_st.temp = temp_prod[31:16];
      nxt_st.temp_valid = 1'b1;
    end
  end

  // State register; reset leaves the filter in its start-up average
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.bus_init <= 1'b1;
      st_ff.al <= PSS_AL_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign speed = st_ff.speed;
  assign speed_valid = st_ff.speed_valid;
  assign electrical_position = st_ff.el_pos;
  assign flux_current_ref = st_ff.id_ref;
  assign align_done = st_ff.aligned;
  assign adc_start = st_ff.adc_start;
  assign phase_a_current = st_ff.ia;
  assign phase_b_current = st_ff.ib;
  assign phase_c_current = st_ff.ic;
  assign current_valid = st_ff.cur_valid;
  assign bus_voltage_filtered = st_ff.bus_filt;
  assign bus_voltage_valid = st_ff.bus_valid;
  assign temperature_c = st_ff.temp;
  assign temperature_valid = st_ff.temp_valid;

endmodule : pss_frontend
`default_nettype wire

// ### inc/pss_pkg.sv
// Constants and types shared by the motor sensing front end.
// Assumes a single 200 MHz system clock; all times are turned into cycle counts here.
package pss_pkg;

  // System clock
  localparam longint CLK_HZ = 200000000; // System clock rate
  localparam longint CLK_PERIOD_NS = 5; // System clock period

  // Encoder and speed measurement
  localparam longint ENC_PULSES_PER_REV = 1024; // Encoder lines per mechanical turn
  localparam longint EDGES_PER_PULSE = 4; // Quadrature edges counted per line
  localparam longint CALC_PERIOD_US = 900; // Speed calculation period
  localparam longint CALC_CYCLES = CLK_HZ / 1000000 * CALC_PERIOD_US; // 180000 cycles
  localparam longint ITV_SIGNED_MAX = 32767; // Period must stay below this many interval ticks
  // Interval timer runs at clk/2, further slowed by a whole prescale so the period fits 15 bits
  localparam longint ITV_PRESC = (CALC_CYCLES / 2 + ITV_SIGNED_MAX - 1) / ITV_SIGNED_MAX;
  localparam logic [3:0] ITV_DIV = 4'(2 * ITV_PRESC); // System cycles per interval tick
  localparam longint INTERVAL_CLOCK_PERIOD_NS = 2 * ITV_PRESC * CLK_PERIOD_NS;
  localparam longint SPEED_MAX_RPM = 6000; // Speed mapped to full scale
  localparam longint SPEED_FRAC_BITS = 15; // Speed result is Q15
  // Scaling constant k, already multiplied by 2^15
  localparam longint SPEED_K = (longint'(60) * (longint'(1) << SPEED_FRAC_BITS) * longint'(1000000000))
    / (EDGES_PER_PULSE * ENC_PULSES_PER_REV * INTERVAL_CLOCK_PERIOD_NS * SPEED_MAX_RPM);
  localparam logic [23:0] SPEED_K_W = 24'(SPEED_K);
  localparam logic [15:0] SPEED_FULL = 16'h7fff; // Positive full scale
  localparam logic [11:0] POS_WRAP = 12'(EDGES_PER_PULSE * ENC_PULSES_PER_REV - 1); // Last count of a turn

  // Rotor alignment
  localparam longint ALIGN_TIME_MS = 500; // Settling time with alignment current applied
  localparam longint ALIGN_CYCLES = CLK_HZ / 1000 * ALIGN_TIME_MS;
  localparam logic [15:0] ALIGN_CURRENT = 16'h2000; // Flux current reference during alignment, Q15

  // DC bus filter
  localparam int BUS_INIT_LOG2 = 4; // Start-up average over 2^4 samples
  localparam logic [4:0] BUS_INIT_N = 5'h10;

  // Temperature: temp = (v - b) / a, b = 2.4596 V, a = -0.0073738 V/degC
  localparam longint TEMP_B_E4 = 24596; // b in units of 0.1 mV
  localparam longint TEMP_A_E7 = -73738; // a in units of 0.1 uV
  localparam logic [15:0] TEMP_B_W = 16'(TEMP_B_E4);
  // 2^16 / (-a in 0.1 mV per degC), rounded
  localparam logic [15:0] TEMP_MUL = 16'(((longint'(65536) * 1000) - TEMP_A_E7 / 2) / (-TEMP_A_E7));

  // Alignment sequence states
  typedef enum logic [1:0] {
    PSS_AL_IDLE,
    PSS_AL_HOLD,
    PSS_AL_CLEAR,
    PSS_AL_DONE
  } pss_align_t;

endpackage : pss_pkg

// ### logic/pss_divider.sv
// Serial unsigned divider, one quotient bit per clock.
// Assumes the caller waits for done before issuing another start.
`timescale 1ns/100ps
`default_nettype none
module pss_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [39:0] dividend,
  input wire logic [15:0] divisor,
  output logic done,
  output logic [39:0] quotient
);
  import pss_pkg::*;

  typedef struct packed {
    logic busy; // Division running
    logic [5:0] step; // Bits still to produce
    logic [16:0] rem; // Partial remainder
    logic [39:0] quo; // Shifts dividend out, quotient in
    logic [15:0] dvs; // Held divisor
    logic done; // One-cycle completion pulse
  } pss_div_t;

  pss_div_t cur_ff, nxt_cur;
  logic [16:0] trial;

  // Restoring division: trade 40 cycles of latency for no wide divider array
  always_comb begin
    nxt_cur = cur_ff;
    trial = 17'h00000;
    nxt_cur.done = 1'b0;
    if (start && !cur_ff.busy) begin
      nxt_cur.busy = 1'b1;
      nxt_cur.step = 6'h28;
      nxt_cur.rem = 17'h00000;
      nxt_cur.quo = dividend;
      nxt_cur.dvs = divisor;
    end else if (cur_ff.busy) begin
      trial = {cur_ff.rem[15:0], cur_ff.quo[39]};
      if (trial >= {1'b0, cur_ff.dvs}) begin
        nxt_cur.rem = trial - {1'b0, cur_ff.dvs};
        nxt_cur.quo = {cur_ff.quo[38:0], 1'b1};
      end else begin
        nxt_cur.rem = trial;
        nxt_cur.quo = {cur_ff.quo[38:0], 1'b0};
      end
      nxt_cur.step = cur_ff.step - 6'h01;
      if (cur_ff.step == 6'h01) begin
        nxt_cur.busy = 1'b0;
        nxt_cur.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign done = cur_ff.done;
  assign quotient = cur_ff.quo;

endmodule : pss_divider
`default_nettype wire

// ### verif/pss_frontend_sva.sv
// Port-level checks for the sensing front end, attached by bind.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module pss_frontend_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic adc_done,
  input wire logic temp_sample_valid,
  input wire logic [15:0] speed,
  input wire logic speed_valid,
  input wire logic [11:0] electrical_position,
  input wire logic [15:0] flux_current_ref,
  input wire logic align_done,
  input wire logic adc_start,
  input wire logic current_valid,
  input wire logic temperature_valid
);
  // Every check runs on the system clock and rests during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // One result per period, so the strobe never stretches
  speed_pulse_a: assert property (speed_valid |=> !speed_valid)
    else $error("speed strobe wider than one cycle");
  // Result register only moves together with its strobe
  speed_hold_a: assert property ($changed(speed) |-> speed_valid)
    else $error("speed changed without strobe");
  // Magnitude clips at full scale, so the most negative code is unused
  speed_clip_a: assert property (speed_valid |-> speed != 16'h8000)
    else $error("speed beyond full scale");
  // Flux reference is either off or the alignment level
  ref_level_a: assert property (flux_current_ref == 16'h0000 || flux_current_ref == 16'h2000)
    else $error("flux reference has an odd value");
  // Position reads zero whenever alignment current is applied
  pos_forced_a: assert property (flux_current_ref != 16'h0000 |-> electrical_position == 12'h000)
    else $error("position not forced during alignment");
  // Current is released only after the counter was cleared
  ref_release_a: assert property (flux_current_ref == 16'h0000 && $past(flux_current_ref) != 16'h0000
    |-> align_done && electrical_position == 12'h000)
    else $error("alignment released out of order");
  // Finished alignment never reapplies current
  done_ref_a: assert property (align_done |-> flux_current_ref == 16'h0000)
    else $error("current applied after alignment");
  // Alignment is a once-per-reset event
  done_sticky_a: assert property (align_done |=> align_done)
    else $error("alignment flag dropped");
  // Conversion trigger is a single-cycle pulse
  start_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("conversion trigger too wide");
  // Rebuilt currents follow each conversion by one cycle
  cur_answer_a: assert property (adc_done |=> current_valid)
    else $error("currents not updated after conversion");
  // Temperature follows each sample by one cycle
  temp_answer_a: assert property (temp_sample_valid |=> temperature_valid)
    else $error("temperature not updated after sample");
endmodule : pss_frontend_sva
bind pss_frontend pss_frontend_sva chk (.clk, .rst, .adc_done, .temp_sample_valid, .speed, .speed_valid,
  .electrical_position, .flux_current_ref, .align_done, .adc_start, .current_valid, .temperature_valid);
`default_nettype wire

// ### verif/pss_partner.sv
// Far-side model: quadrature encoder, PWM reload source and ADC handshake.
// Assumes the bench sets the wheel rate; everything changes just after clk rises.
`timescale 1ns/100ps
`default_nettype none
module pss_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] enc_step, // Cycles per quadrature state, 0 holds the wheel
  input wire logic enc_rev, // Turn backwards
  input wire logic adc_start,
  output logic enc_a,
  output logic enc_b,
  output logic pwm_sync,
  output logic adc_done
);
  localparam int PWM_CYCLES = 300; // Short PWM period keeps the run brief
  localparam int ADC_LAT = 4; // Conversion time in cycles
  int ecnt; // Wheel step timer
  int pcnt; // PWM carrier position
  int acnt; // Conversion timer
  logic [1:0] phase; // Wheel state 0..3
  // Wheel, carrier and converter advance together
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ecnt <= 0;
      pcnt <= 0;
      acnt <= 0;
      phase <= 2'h0;
      pwm_sync <= 1'b0;
      adc_done <= 1'b0;
    end else begin
      // A still wheel keeps its last state, as a real encoder does
      if (enc_step == 16'h0000) begin
        ecnt <= 0;
      end else if (ecnt + 1 >= int'(enc_step)) begin
        ecnt <= 0;
        phase <= enc_rev ? phase - 2'h1 : phase + 2'h1;
      end else begin
        ecnt <= ecnt + 1;
      end
      // Reload at the carrier centre, pulse on every reload whatever the load permit
      pcnt <= (pcnt == PWM_CYCLES - 1) ? 0 : pcnt + 1;
      pwm_sync <= (pcnt < 2);
      // Conversion ends a fixed time after its trigger
      if (adc_start) begin
        acnt <= ADC_LAT;
      end else if (acnt != 0) begin
        acnt <= acnt - 1;
      end
      adc_done <= (acnt == 1);
    end
  end
  // Gray sequence 00,10,11,01 so A leads B when turning forward
  assign enc_a = phase[1] ^ phase[0];
  assign enc_b = phase[1];
endmodule : pss_partner
`default_nettype wire

// ### verif/pss_frontend_bench.sv
// Self-checking bench for the sensing front end with shortened counts.
// Assumes pss_partner drives the encoder, PWM sync and ADC done lines.
`timescale 1ns/100ps
`default_nettype none
module pss_frontend_bench;
  localparam int CALC = 2000; // Short speed period, still far below the 15-bit tick limit
  localparam int HOLD = 50; // Short alignment hold
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run_switch = 1'b0;
  logic bus_sample_valid = 1'b0;
  logic temp_sample_valid = 1'b0;
  logic enc_rev = 1'b0;
  logic [2:0] sector = 3'h1;
  logic [15:0] sample_delay = 16'h0005;
  logic [15:0] adc_ia = 16'h0000, adc_ib = 16'h0000, adc_ic = 16'h0000;
  logic [15:0] bus_sample = 16'h0000, filter_coef = 16'h7fff, temp_sense_mv10 = 16'h0000, enc_step = 16'h0000;
  logic enc_a, enc_b, pwm_sync, adc_done, speed_valid, align_done, adc_start;
  logic current_valid, bus_voltage_valid, temperature_valid;
  logic [11:0] electrical_position;
  logic [15:0] speed, flux_current_ref, phase_a_current, phase_b_current, phase_c_current;
  logic [15:0] bus_voltage_filtered, temperature_c;
  int errors = 0;
  int num_checks = 0;
  pss_frontend #(.CALC_PERIOD_CYCLES(CALC), .ALIGN_HOLD_CYCLES(HOLD)) dut (
    .clk, .rst, .enc_a, .enc_b, .run_switch, .pwm_sync, .sample_delay, .adc_done, .sector,
    .adc_ia, .adc_ib, .adc_ic, .bus_sample_valid, .bus_sample, .filter_coef, .temp_sample_valid,
    .temp_sense_mv10, .speed, .speed_valid, .electrical_position, .flux_current_ref, .align_done,
    .adc_start, .phase_a_current, .phase_b_current, .phase_c_current, .current_valid,
    .bus_voltage_filtered, .bus_voltage_valid, .temperature_c, .temperature_valid
  );
  pss_partner far_side (.clk, .rst, .enc_step, .enc_rev, .adc_start, .enc_a, .enc_b, .pwm_sync, .adc_done);
  // 200 MHz system clock
  always #2.5 clk = ~clk;
  // Compare one value, counting every comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // Bounded wait at falling edges, returns at once if already high
  task automatic wait_for(ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n == 5000) chk(16'h0000, 16'h0001);
  endtask : wait_for
  // Alignment with the wheel moving during the hold, then a second start
  task automatic t_align();
    run_switch = 1'b1;
    enc_step = 16'h0005;
    repeat (6) @(negedge clk);
    chk(flux_current_ref, 16'h2000);
    chk({4'h0, electrical_position}, 16'h0000);
    repeat (14) @(negedge clk);
    enc_step = 16'h0000;
    wait_for(align_done);
    chk(flux_current_ref, 16'h0000);
    chk({4'h0, electrical_position}, 16'h0000);
    run_switch = 1'b0;
    repeat (10) @(negedge clk);
    run_switch = 1'b1;
    repeat (10) @(negedge clk);
    chk(flux_current_ref, 16'h0000);
    $display("test align done");
  endtask : t_align
  // Cycles from a sync rise to the conversion trigger
  task automatic lat(input logic [15:0] d, output int n);
    sample_delay = d;
    wait_for(pwm_sync);
    repeat (3) @(negedge clk);
    wait_for(pwm_sync);
    n = 0;
    while (adc_start !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask : lat
  task automatic t_adc();
    int l0, l1;
    lat(16'h0005, l0);
    lat(16'h0014, l1);
    chk(16'(l1 - l0), 16'h000f);
    $display("test trigger done");
  endtask : t_adc
  // Every sector with a plain, a positive-clip and a negative-clip case
  task automatic t_cur();
    logic [15:0] vin [3] = '{16'h0c00, 16'h6000, 16'ha000};
    logic [15:0] vex [3] = '{16'he800, 16'h8000, 16'h7fff};
    logic [15:0] got;
    for (int s = 1; s <= 6; s++) begin
      for (int i = 0; i < 3; i++) begin
        sector = 3'(s);
        adc_ia = vin[i];
        adc_ib = vin[i];
        adc_ic = vin[i];
        wait_for(current_valid);
        @(negedge clk);
        wait_for(current_valid);
        got = (s == 1 || s == 6) ? phase_a_current : (s < 4) ? phase_b_current : phase_c_current;
        chk(got, vex[i]);
      end
    end
    $display("test currents done");
  endtask : t_cur
  // Speed after a few periods at a fixed wheel rate
  task automatic t_speed(input logic [15:0] step, input logic rev, input logic [15:0] exp);
    enc_step = step;
    enc_rev = rev;
    repeat (4) begin
      wait_for(speed_valid);
      @(negedge clk);
    end
    chk(speed, exp);
    $display("test speed done");
  endtask : t_speed
  task automatic bus_put(input logic [15:0] v, input logic ev);
    bus_sample = v;
    bus_sample_valid = 1'b1;
    @(negedge clk);
    chk(16'(bus_voltage_valid), 16'(ev));
    bus_sample_valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask : bus_put
  // Sixteen rising samples seed the filter, then one step is filtered
  task automatic t_bus();
    for (int i = 0; i < 16; i++) bus_put(16'h1000 + 16'(i * 16), i == 15);
    chk(bus_voltage_filtered, 16'h1078);
    bus_put(16'h3000, 1'b1);
    chk(bus_voltage_filtered, 16'h203b);
    $display("test bus done");
  endtask : t_bus
  task automatic temp_put(input logic [15:0] v, input logic [15:0] exp);
    temp_sense_mv10 = v;
    temp_sample_valid = 1'b1;
    @(negedge clk);
    temp_sample_valid = 1'b0;
    wait_for(temperature_valid);
    chk(temperature_c, exp);
  endtask : temp_put
  // Main sequence: reset held four cycles, then each scenario
  initial begin
    @(negedge clk);
    chk(speed, 16'h0000);
    chk(flux_current_ref, 16'h0000);
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_align();
    t_adc();
    t_cur();
    // Each tick is 6 cycles: 600-cycle steps give 2 counts per 200 ticks
    t_speed(16'h0258, 1'b0, 16'h682a);
    t_speed(16'h0258, 1'b1, 16'h97d6);
    t_speed(16'h003c, 1'b0, 16'h7fff);
    t_speed(16'h0000, 1'b0, 16'h0000);
    t_bus();
    // Offset voltage reads zero; readings round toward minus infinity
    temp_put(16'h6014, 16'h0000);
    temp_put(16'h40d4, 16'h006c);
    temp_put(16'h7530, 16'hffb6);
    $display("test temperature done");
    close_out();
  end
  // Watchdog: the sequence needs about 38k cycles
  initial begin
    #400000;
    chk(16'h0000, 16'h0001);
    close_out();
  end
endmodule : pss_frontend_bench
`default_nettype wire
